// ===== port_pm_pkg.sv
// Purpose: constants for the port power management register bank
// Assumes: 32-bit word registers on an AHB-Lite slave
// Notes:   byte offsets, field positions, reset values
package port_pm_pkg;
   localparam logic [11:0] cap_upper_offset   = 12'h0_0c0;
   localparam logic [11:0] ctrl_status_offset = 12'h0_0c4;
   localparam logic [11:0] irq_status_offset  = 12'h0_100;
   localparam logic [11:0] irq_mask_offset    = 12'h0_104;
   localparam logic [11:0] event_ctrl_offset  = 12'h0_108;
   localparam int vendor_init_bit      = 21;
   localparam int wake_states_lsb      = 27;
   localparam int power_state_lsb      = 0;
   localparam int context_bit          = 3;
   localparam int wake_enable_bit      = 8;
   localparam int wake_status_bit      = 15;
   localparam logic [4:0] wake_states_reset = 5'h19;
   localparam logic       vendor_init_reset = 1'b0;
   localparam logic       context_reset     = 1'b1;
   localparam logic [1:0] state_d0          = 2'h0;
   localparam logic [1:0] state_d3hot       = 2'h3;
   localparam logic [3:0] cap_fixed_id      = 4'h0;
   localparam int irq_wake_bit   = 0;
   localparam int irq_d0_bit     = 1;
   localparam int irq_width      = 2;
   localparam logic [1:0] htrans_nonseq = 2'h2;
   localparam logic [2:0] hsize_word    = 3'h2;
endpackage : port_pm_pkg

// ===== port_power_mgmt_regs.sv
// Purpose: power management capability and control/status registers
// Assumes: one clock, AHB-Lite slave, zero wait states, always OKAY
// Notes:   sticky bits reset only by nrst, not by hot_reset
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
// Function
// R1: vendor init bit defaults to zero
// R2: aux current field always reads zero
// R3: d1 and d2 support bits read zero
// R4: wake states field defaults to 11001
// R5: wake states writes change readback only
// R6: no wake forwarding while in d3cold
// R7: power state field reports and accepts state
// R8: encodings one and two are reserved
// R9: context flag defaults one, preserves context
// R10: wake enable bit defaults zero, sticky
// R11: hot reset leaves wake enable alone
// R12: own wake sets status; write one clears
// R13: forwarded wake leaves status unchanged
// R14: upstream port never sets wake status
// R15: data fields unimplemented, read zero
// R16: bus power and clock bits read zero
// R17: loader may preset wake enable
// R18: capability bits 19 and 20 read zero
// R19: reserved bits ignore writes, zero ignored
module port_power_mgmt_regs
   import port_pm_pkg::*;
#(
   parameter logic upstream_port = 1'b0
) (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        hot_reset,
   input  wire logic        d3cold,
   input  wire logic        own_wake_event,
   input  wire logic        fwd_wake_in,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             wake_msg,
   output logic             fwd_wake_out,
   output logic             context_reset_pulse,
   output logic [1:0]       power_state_out,
   output logic             irq
);
   logic [4:0]  wake_states;
   logic        vendor_init;
   logic [1:0]  power_state;
   logic        context_flag;
   logic        wake_event_enable;
   logic        wake_event_status;
   logic [irq_width-1:0] irq_status;
   logic [irq_width-1:0] irq_mask;
   logic        wr_pend;
   logic [11:0] wr_addr;
   logic [31:0] rd_word;

   wire         addr_ok   = hsel && hready && htrans == htrans_nonseq;
   wire         wr_cap    = wr_pend && wr_addr == cap_upper_offset;
   wire         wr_csr    = wr_pend && wr_addr == ctrl_status_offset;
   wire         wr_ist    = wr_pend && wr_addr == irq_status_offset;
   wire         wr_imask  = wr_pend && wr_addr == irq_mask_offset;
   wire [1:0]   wr_state  = hwdata[power_state_lsb +: 2];
   wire         state_ok  = wr_state == state_d0 || wr_state == state_d3hot;
   // wake generation ignores the advertised wake states, fixed or readback copy
   wire         gen_wake  = own_wake_event && !upstream_port && !d3cold; // R5 R6 R14
   wire         clr_wake  = wr_csr && hwdata[wake_status_bit];
   wire         leave_d3  = wr_csr && state_ok && power_state == state_d3hot
                            && wr_state == state_d0;
   wire [31:0]  cap_word  = {wake_states, 1'b0, 1'b0, 3'h0,
                             vendor_init, 5'h00, 16'h0_000}; // R2 R3 R18
   wire [31:0]  csr_word  = {16'h0_000, wake_event_status, 6'h00,
                             wake_event_enable, 4'h0, context_flag, 1'b0,
                             power_state}; // R15 R16 R19
   always_comb begin
      if (haddr[11:0] == cap_upper_offset)
         rd_word = cap_word;
      else if (haddr[11:0] == ctrl_status_offset)
         rd_word = csr_word;
      else if (haddr[11:0] == irq_status_offset)
         rd_word = {30'h0, irq_status};
      else if (haddr[11:0] == irq_mask_offset)
         rd_word = {30'h0, irq_mask};
      else
         rd_word = 32'h0_000;
   end
   wire [irq_width-1:0] irq_events = {leave_d3, gen_wake};
   wire [irq_width-1:0] next_irq_status =
      irq_events | (irq_status & ~(wr_ist ? hwdata[irq_width-1:0] : '0));

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h0_000;
         hrdata  <= 32'h0_000;
      end else begin
         wr_pend <= addr_ok && hwrite;
         wr_addr <= haddr[11:0];
         hrdata  <= (addr_ok && !hwrite) ? rd_word : 32'h0_000;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // capability fields
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wake_states <= wake_states_reset; // R4
         vendor_init <= vendor_init_reset; // R1
      end else if (hot_reset) begin
         wake_states <= wake_states_reset;
         vendor_init <= vendor_init_reset;
      end else if (wr_cap) begin
         wake_states <= hwdata[wake_states_lsb +: 5]; // R5
         vendor_init <= hwdata[vendor_init_bit];
      end
   end

   // power state and context flag, reset to d0 and one by hot reset
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         power_state  <= state_d0;
         context_flag <= context_reset; // R9
      end else if (hot_reset) begin
         power_state  <= state_d0;
         context_flag <= context_reset;
      end else if (wr_csr) begin
         if (state_ok)
            power_state <= wr_state; // R7 R8
         context_flag <= hwdata[context_bit];
      end
   end

   // sticky wake bits survive hot reset
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wake_event_enable <= 1'b0; // R10
         wake_event_status <= 1'b0;
      end else begin
         if (wr_csr)
            wake_event_enable <= hwdata[wake_enable_bit]; // R10 R11 R17
         // set wins over clear; forwarded events never touch it
         wake_event_status <= gen_wake | (wake_event_status & ~clr_wake); // R12 R13 R14 R19
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_status <= '0;
         irq_mask   <= '0;
      end else begin
         irq_status <= next_irq_status;
         if (wr_imask)
            irq_mask <= hwdata[irq_width-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wake_msg            <= 1'b0;
         fwd_wake_out        <= 1'b0;
         context_reset_pulse <= 1'b0;
         power_state_out     <= state_d0;
         irq                 <= 1'b0;
      end else begin
         wake_msg            <= gen_wake && wake_event_enable; // R10
         fwd_wake_out        <= fwd_wake_in && !d3cold; // R6
         context_reset_pulse <= leave_d3 && !context_flag; // R9
         power_state_out     <= power_state;
         irq                 <= |(next_irq_status & irq_mask);
      end
   end

   sequence s_leave_d3hot;
      wr_csr && state_ok && power_state == state_d3hot && wr_state == state_d0;
   endsequence : s_leave_d3hot

   sequence s_own_wake;
      own_wake_event && !d3cold && !upstream_port;
   endsequence : s_own_wake

   a_status_sets: assert property ( // R12
      @(posedge sys_clk) disable iff (!nrst)
      gen_wake |=> wake_event_status)
      else $error("wake status not set");

   a_status_clears: assert property ( // R12
      @(posedge sys_clk) disable iff (!nrst)
      clr_wake && !gen_wake |=> !wake_event_status)
      else $error("wake status not cleared");

   a_fwd_no_status: assert property ( // R13
      @(posedge sys_clk) disable iff (!nrst)
      !gen_wake && !wake_event_status |=> !wake_event_status)
      else $error("status set without own event");

   a_upstream_never: assert property ( // R14
      @(posedge sys_clk) disable iff (!nrst)
      upstream_port |-> !wake_event_status)
      else $error("upstream status set");

   a_hot_keeps_en: assert property ( // R11
      @(posedge sys_clk) disable iff (!nrst)
      hot_reset && !wr_csr |=> $stable(wake_event_enable))
      else $error("hot reset changed enable");

   a_no_d3cold_fwd: assert property ( // R6
      @(posedge sys_clk) disable iff (!nrst)
      d3cold |=> !fwd_wake_out && !wake_msg)
      else $error("wake forwarded in d3cold");

   a_state_legal: assert property ( // R8
      @(posedge sys_clk) disable iff (!nrst)
      power_state == state_d0 || power_state == state_d3hot)
      else $error("reserved power state held");

   a_csr_zeros: assert property ( // R15
      @(posedge sys_clk) disable iff (!nrst)
      (csr_word & 32'hFFFF_7EF4) == 32'h0_000)
      else $error("csr reserved bits set");

   a_cap_zeros: assert property ( // R3
      @(posedge sys_clk) disable iff (!nrst)
      (cap_word & 32'h07D8_0000) == 32'h0_000)
      else $error("cap fixed bits set");

   a_enable_msg: assert property ( // R10
      @(posedge sys_clk) disable iff (!nrst)
      wake_msg |-> $past(wake_event_enable) && wake_event_status)
      else $error("wake message without enable");

   a_ctx_pulse_on: assert property ( // R9
      @(posedge sys_clk) disable iff (!nrst)
      s_leave_d3hot ##0 !context_flag |=> context_reset_pulse)
      else $error("context reset pulse missing");

   a_ctx_pulse_cause: assert property ( // R9
      @(posedge sys_clk) disable iff (!nrst)
      context_reset_pulse |-> $past(leave_d3) && !$past(context_flag))
      else $error("context reset pulse without cause");

   a_ctx_kept: assert property ( // R9
      @(posedge sys_clk) disable iff (!nrst)
      leave_d3 && context_flag |=> !context_reset_pulse)
      else $error("context reset while preserved");

   a_wake_msg_on: assert property ( // R10
      @(posedge sys_clk) disable iff (!nrst)
      s_own_wake ##0 wake_event_enable |=> wake_msg)
      else $error("wake message missing");

   a_status_no_enable: assert property ( // R12
      @(posedge sys_clk) disable iff (!nrst)
      s_own_wake ##0 !wake_event_enable |=> wake_event_status && !wake_msg)
      else $error("status or message wrong with enable clear");

   a_fwd_follows: assert property ( // R6
      @(posedge sys_clk) disable iff (!nrst)
      fwd_wake_in && !d3cold |=> fwd_wake_out)
      else $error("forwarded wake missing");

   a_fwd_cause: assert property ( // R6
      @(posedge sys_clk) disable iff (!nrst)
      fwd_wake_out |-> $past(fwd_wake_in) && !$past(d3cold))
      else $error("forwarded wake without cause");

   a_cold_no_status: assert property ( // R6
      @(posedge sys_clk) disable iff (!nrst)
      d3cold && !wake_event_status |=> !wake_event_status)
      else $error("status set in d3cold");

   a_state_write: assert property ( // R7
      @(posedge sys_clk) disable iff (!nrst)
      wr_csr && state_ok && !hot_reset |=> power_state == $past(wr_state))
      else $error("power state not written");

   a_state_reserved: assert property ( // R8
      @(posedge sys_clk) disable iff (!nrst)
      wr_csr && !state_ok && !hot_reset |=> $stable(power_state))
      else $error("reserved power state accepted");

   a_ctx_hot: assert property ( // R9
      @(posedge sys_clk) disable iff (!nrst)
      hot_reset |=> context_flag && power_state == state_d0)
      else $error("hot reset missed state or context");

   a_cap_hot: assert property ( // R4
      @(posedge sys_clk) disable iff (!nrst)
      hot_reset |=> wake_states == wake_states_reset && !vendor_init)
      else $error("hot reset missed capability fields");

   a_en_write: assert property ( // R10
      @(posedge sys_clk) disable iff (!nrst)
      wr_csr |=> wake_event_enable == $past(hwdata[wake_enable_bit]))
      else $error("wake enable not written");

   a_en_hold: assert property ( // R11
      @(posedge sys_clk) disable iff (!nrst)
      !wr_csr |=> $stable(wake_event_enable))
      else $error("wake enable changed without write");

   a_status_w0: assert property ( // R19
      @(posedge sys_clk) disable iff (!nrst)
      wr_csr && !hwdata[wake_status_bit] && wake_event_status
         |=> wake_event_status)
      else $error("zero write cleared status");

   a_states_readback: assert property ( // R5
      @(posedge sys_clk) disable iff (!nrst)
      wr_cap && !hot_reset |=> wake_states == $past(hwdata[31:27]))
      else $error("wake states not written");

   a_vendor_write: assert property ( // R1
      @(posedge sys_clk) disable iff (!nrst)
      wr_cap && !hot_reset |=> vendor_init == $past(hwdata[vendor_init_bit]))
      else $error("vendor init not written");

   a_irq_set: assert property ( // R12
      @(posedge sys_clk) disable iff (!nrst)
      gen_wake |=> irq_status[irq_wake_bit])
      else $error("wake irq status not set");

   a_irq_d3_exit: assert property ( // R9
      @(posedge sys_clk) disable iff (!nrst)
      leave_d3 |=> irq_status[irq_d0_bit])
      else $error("d3hot exit irq status not set");

   a_rdata_idle: assert property ( // R19
      @(posedge sys_clk) disable iff (!nrst)
      !$past(addr_ok && !hwrite) |-> hrdata == 32'h0_000)
      else $error("read data outside data phase");

   a_rd_csr_zero: assert property ( // R15
      @(posedge sys_clk) disable iff (!nrst)
      $past(addr_ok && !hwrite && haddr[11:0] == ctrl_status_offset)
         |-> (hrdata & 32'hFFFF_7EF4) == 32'h0_000)
      else $error("csr read shows reserved bits");

   a_rd_cap_zero: assert property ( // R18
      @(posedge sys_clk) disable iff (!nrst)
      $past(addr_ok && !hwrite && haddr[11:0] == cap_upper_offset)
         |-> (hrdata & 32'h07D8_0000) == 32'h0_000)
      else $error("cap read shows fixed bits");
endmodule : port_power_mgmt_regs

// ===== testbench.sv
// Purpose: self-checking bench for the power management register bank
// Assumes: zero-wait AHB-Lite slave, one clock, async active-low reset
// Notes:   random control/status writes checked against a bench model
`timescale 1ns/1ps
module testbench;
   import port_pm_pkg::*;
   logic        sys_clk = 0, nrst = 0, hot_reset = 0, d3cold = 0;
   logic        own_wake_event = 0, fwd_wake_in = 0, hsel = 0, hwrite = 0;
   logic        hready = 1;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0]  htrans = 0, power_state_out, st;
   logic [2:0]  hsize = hsize_word;
   logic        hreadyout, hresp, wake_msg, fwd_wake_out, irq, ctx, en, ws;
   logic        context_reset_pulse;
   int          n_mismatch = 0, n_compared = 0, cycles = 0, i;
   integer      seed = 32'h3231_9547;
   logic [31:0] d;
   port_power_mgmt_regs uut (.sys_clk(sys_clk), .nrst(nrst),
      .hot_reset(hot_reset), .d3cold(d3cold), .own_wake_event(own_wake_event),
      .fwd_wake_in(fwd_wake_in), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .wake_msg(wake_msg), .fwd_wake_out(fwd_wake_out),
      .context_reset_pulse(context_reset_pulse),
      .power_state_out(power_state_out), .irq(irq));
   always #25 sys_clk = ~sys_clk;
   task complete_run;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
      @(posedge sys_clk);
      hsel <= 1; haddr <= {20'h0_0000, a}; hwrite <= w;
      htrans <= htrans_nonseq;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0; hsel <= 0; hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      bus(a, 0, 32'h0000_0000);
      chk(rd, exp);
   endtask : rdchk
   function automatic logic [31:0] csr(input logic [1:0] s,
                                       input logic c, e, w);
      csr = {16'h0000, w, 6'h00, e, 4'h0, c, 1'b0, s};
   endfunction : csr
   task pulse_wake;
      @(posedge sys_clk) own_wake_event <= 1;
      @(posedge sys_clk) own_wake_event <= 0;
      #1 chk(wake_msg, 1);
   endtask : pulse_wake
   initial begin
      repeat (8) @(posedge sys_clk);
      nrst <= 1;
      @(posedge sys_clk) chk({hreadyout, hresp}, 2'b10);
      rdchk(cap_upper_offset, 32'hc800_0000);
      rdchk(ctrl_status_offset, 32'h0000_0008);
      bus(cap_upper_offset, 1, 32'hffff_ffff);
      rdchk(cap_upper_offset, 32'hf820_0000);
      bus(ctrl_status_offset, 1, 32'hffff_ffff);
      rdchk(ctrl_status_offset, 32'h0000_010b);
      for (i = 1; i < 3; i++) begin
         bus(ctrl_status_offset, 1, 32'h0000_0108 | i);
         rdchk(ctrl_status_offset, 32'h0000_010b);
      end
      chk(power_state_out, state_d3hot);
      @(posedge sys_clk) hot_reset <= 1;
      @(posedge sys_clk) hot_reset <= 0;
      rdchk(ctrl_status_offset, 32'h0000_0108);
      rdchk(cap_upper_offset, 32'hc800_0000);
      bus(irq_mask_offset, 1, 32'h0000_0003);
      pulse_wake();
      rdchk(ctrl_status_offset, 32'h0000_8108);
      rdchk(irq_status_offset, 32'h0000_0001);
      chk(irq, 1);
      bus(ctrl_status_offset, 1, 32'h0000_0108);
      rdchk(ctrl_status_offset, 32'h0000_8108);
      bus(irq_status_offset, 1, 32'h0000_0003);
      repeat (2) @(posedge sys_clk);
      chk(irq, 0);
      for (i = 0; i < 2; i++) begin
         @(posedge sys_clk) begin d3cold <= i[0]; fwd_wake_in <= 1; end
         @(posedge sys_clk) fwd_wake_in <= 0;
         #1 chk(fwd_wake_out, !i[0]);
      end
      d3cold <= 0;
      rdchk(ctrl_status_offset, 32'h0000_8108);
      rdchk(event_ctrl_offset, 32'h0000_0000);
      bus(ctrl_status_offset, 1, 32'h0000_8003);
      bus(ctrl_status_offset, 1, 32'h0000_0000);
      #1 chk(context_reset_pulse, 1);
      rdchk(irq_status_offset, 32'h0000_0002);
      @(posedge sys_clk) own_wake_event <= 1;
      @(posedge sys_clk) own_wake_event <= 0;
      #1 chk(wake_msg, 0);
      rdchk(ctrl_status_offset, 32'h0000_8000);
      rdchk(irq_status_offset, 32'h0000_0003);
      bus(ctrl_status_offset, 1, 32'h0000_8108);
      @(posedge sys_clk) begin d3cold <= 1; own_wake_event <= 1; end
      @(posedge sys_clk) begin d3cold <= 0; own_wake_event <= 0; end
      #1 chk(wake_msg, 0);
      rdchk(ctrl_status_offset, 32'h0000_0108);
      st = 0; ctx = 1; en = 1; ws = 0;
      for (i = 0; i < 16; i++) begin
         d = $random(seed);
         bus(ctrl_status_offset, 1, d);
         if (d[1:0] == state_d0 || d[1:0] == state_d3hot) st = d[1:0];
         ctx = d[3]; en = d[8]; ws = ws & !d[15];
         rdchk(ctrl_status_offset, csr(st, ctx, en, ws));
      end
      complete_run();
   end
endmodule : testbench
